/* File: bst_tap.sv */
/*
 Boundary scan test access port with 81-cell boundary register,
 identification, sample/preload, extest and bypass.
 Assumes the tester owns the test clock, mode select, data in and
 test reset; functional cell values arrive on the core clock.
*/
// Operation
// [R1] The port uses only the five test pins, which do nothing else.
// [R2] Test reset low puts the controller in reset at once, clock or not.
// [R3] Every pin and analog/digital boundary has a chained scan cell.
// [R4] Vectors shift in on data in, can be applied, and results shift out.
// [R5] An identification register is selected by its own instruction.
// [R6] Identification holds version, part number, maker, then a marker.
// [R7] Both variants share the part number, only the version may differ.
// [R8] Four instructions each pick the register between data in and out.
// [R9] The standard 16-state controller sequences all access on TMS.
// [R10] The boundary register has cells 0 to 80, the top two capture 0.
// [R11] Cell 0 at 1 floats lower pixel bus bits 0 to 3.
// [R12] Cell 2 at 1 floats lower pixel bus bits 4 to 7.
// [R13] Cell 28 at 0 floats the sync, clock and upper pixel bus outputs.
// [R14] Cell 59 is the open-drain data pin, released at 1; 60 reads it.
// [R15] Cell 36 is the open-drain test pin, released high at 0.
// [R16] The identification marker bit is 1 and bypass captures 0.
// [R17] After test reset the instruction is idcode.
`timescale 1ns/1ps
`default_nettype none
module bst_tap #(
  parameter logic [3:0] ID_VERSION = 4'h0
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic i_trst_n,
  output logic o_tdo,
  output logic o_tdo_oe,
  input wire logic [bst_pkg::BSR_LEN-1:0] i_func_cells,
  output logic [bst_pkg::BSR_LEN-1:0] o_cells,
  output logic o_lower_lo_hiz,
  output logic o_lower_hi_hiz,
  output logic o_upper_hiz,
  output logic o_sda_pull_low,
  output logic o_test_pin_pull_low
);
  import bst_pkg::*;

  localparam logic [ID_LEN-1:0] ID_VALUE =
    {ID_VERSION, ID_PART, ID_MAKER, ID_MARKER}; // [R6] [R7] [R16]

  // ==========================================
  // Controller, test clock domain
  bst_state_t state_ff, nxt_state;

  always_comb begin
    unique case (state_ff) // [R9]
      ST_RESET: nxt_state = i_tms ? ST_RESET : ST_IDLE;
      ST_IDLE: nxt_state = i_tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: nxt_state = i_tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: nxt_state = i_tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: nxt_state = i_tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: nxt_state = i_tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: nxt_state = i_tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: nxt_state = i_tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: nxt_state = i_tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: nxt_state = i_tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: nxt_state = i_tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: nxt_state = i_tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: nxt_state = i_tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: nxt_state = i_tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: nxt_state = i_tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: nxt_state = i_tms ? ST_SEL_DR : ST_IDLE;
    endcase
  end

  // Test reset acts without the clock
  always_ff @(posedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      state_ff <= ST_RESET; // [R2]
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================
  // Functional values into the test clock domain
  logic [BSR_LEN-1:0] cap_s1_ff, cap_s2_ff;

  always_ff @(posedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      cap_s1_ff <= '0;
      cap_s2_ff <= '0;
    end else begin
      cap_s1_ff <= i_func_cells;
      cap_s2_ff <= cap_s1_ff;
    end
  end

  // ==========================================
  // Instruction and data registers
  logic [IR_LEN-1:0] ir_sh_ff, ir_ff, nxt_ir_sh, nxt_ir;
  logic [BSR_LEN-1:0] bsr_sh_ff, bsr_upd_ff, nxt_bsr_sh, nxt_bsr_upd;
  logic [ID_LEN-1:0] id_sh_ff, nxt_id_sh;
  logic byp_ff, nxt_byp;
  logic upd_tgl_ff, nxt_upd_tgl;
  logic extest_ff, nxt_extest;
  logic sel_bsr, sel_id;

  always_comb begin
    sel_bsr = (ir_ff == OP_EXTEST) || (ir_ff == OP_SAMPLE); // [R8]
    sel_id = (ir_ff == OP_IDCODE); // [R5]
    nxt_ir_sh = ir_sh_ff;
    nxt_ir = ir_ff;
    nxt_bsr_sh = bsr_sh_ff;
    nxt_bsr_upd = bsr_upd_ff;
    nxt_id_sh = id_sh_ff;
    nxt_byp = byp_ff;
    nxt_upd_tgl = upd_tgl_ff;
    unique case (state_ff)
      ST_RESET: nxt_ir = OP_IDCODE; // [R17]
      ST_CAP_IR: nxt_ir_sh = IR_CAPTURE;
      ST_SH_IR: nxt_ir_sh = {i_tdi, ir_sh_ff[IR_LEN-1:1]};
      ST_UPD_IR: nxt_ir = ir_sh_ff;
      ST_CAP_DR: begin
        nxt_byp = 1'b0; // [R16]
        nxt_id_sh = ID_VALUE; // [R5]
        nxt_bsr_sh = cap_s2_ff; // [R3]
        nxt_bsr_sh[CELL_FIXED_LO] = 1'b0; // [R10]
        nxt_bsr_sh[CELL_FIXED_HI] = 1'b0; // [R10]
      end
      ST_SH_DR: begin // [R4]
        nxt_byp = i_tdi;
        nxt_id_sh = {i_tdi, id_sh_ff[ID_LEN-1:1]};
        nxt_bsr_sh = {i_tdi, bsr_sh_ff[BSR_LEN-1:1]};
      end
      ST_UPD_DR: begin
        if (sel_bsr) begin
          nxt_bsr_upd = bsr_sh_ff; // [R4]
          nxt_upd_tgl = ~upd_tgl_ff;
        end
      end
      default: begin
      end
    endcase
    // Tracks the new instruction at once; the test clock may stop here
    nxt_extest = (nxt_ir == OP_EXTEST);
  end

  always_ff @(posedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      ir_sh_ff <= IR_CAPTURE;
      ir_ff <= OP_IDCODE; // [R17]
      bsr_sh_ff <= '0;
      bsr_upd_ff <= BSR_SAFE;
      id_sh_ff <= '0;
      byp_ff <= 1'b0;
      upd_tgl_ff <= 1'b0;
      extest_ff <= 1'b0;
    end else begin
      ir_sh_ff <= nxt_ir_sh;
      ir_ff <= nxt_ir;
      bsr_sh_ff <= nxt_bsr_sh;
      bsr_upd_ff <= nxt_bsr_upd;
      id_sh_ff <= nxt_id_sh;
      byp_ff <= nxt_byp;
      upd_tgl_ff <= nxt_upd_tgl;
      extest_ff <= nxt_extest;
    end
  end

  // ==========================================
  // Serial out, changes on the falling test clock
  logic nxt_tdo, nxt_tdo_oe;

  always_comb begin
    nxt_tdo_oe = (state_ff == ST_SH_DR) || (state_ff == ST_SH_IR); // [R4]
    if (state_ff == ST_SH_IR) begin
      nxt_tdo = ir_sh_ff[0];
    end else if (sel_bsr) begin
      nxt_tdo = bsr_sh_ff[0];
    end else if (sel_id) begin
      nxt_tdo = id_sh_ff[0];
    end else begin
      nxt_tdo = byp_ff; // [R8]
    end
  end

  always_ff @(negedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else begin
      o_tdo <= nxt_tdo;
      o_tdo_oe <= nxt_tdo_oe; // [R1]
    end
  end

  // ==========================================
  // Update word into the core domain
  // Toggle handshake: the word stays still for several test clocks
  // after each update, far longer than the three-flop delay here.
  logic tgl_s1_ff, tgl_s2_ff, tgl_s3_ff, ext_s1_ff, ext_s2_ff;
  logic [BSR_LEN-1:0] upd_core_ff, cells_ff, nxt_upd_core, nxt_cells;

  always_comb begin
    nxt_upd_core = upd_core_ff;
    if (tgl_s2_ff != tgl_s3_ff) begin
      nxt_upd_core = bsr_upd_ff;
    end
    nxt_cells = ext_s2_ff ? upd_core_ff : i_func_cells; // [R4]
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tgl_s1_ff <= 1'b0;
      tgl_s2_ff <= 1'b0;
      tgl_s3_ff <= 1'b0;
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      upd_core_ff <= BSR_SAFE;
      cells_ff <= BSR_SAFE;
    end else begin
      tgl_s1_ff <= upd_tgl_ff;
      tgl_s2_ff <= tgl_s1_ff;
      tgl_s3_ff <= tgl_s2_ff;
      ext_s1_ff <= extest_ff;
      ext_s2_ff <= ext_s1_ff;
      upd_core_ff <= nxt_upd_core;
      cells_ff <= nxt_cells;
    end
  end

  // ==========================================
  // Pin controls
  assign o_cells = cells_ff;
  assign o_lower_lo_hiz = cells_ff[CELL_LOWER_LO_CTL]; // [R11]
  assign o_lower_hi_hiz = cells_ff[CELL_LOWER_HI_CTL]; // [R12]
  assign o_upper_hiz = ~cells_ff[CELL_UPPER_CTL]; // [R13]
  assign o_sda_pull_low = ~cells_ff[CELL_SDA_OUT]; // [R14]
  // Released to a weak high when the cell holds 0
  assign o_test_pin_pull_low = cells_ff[CELL_TEST_PIN]; // [R15]

  // ==========================================
  // Checks
  sequence tms_high_five;
    i_tms [*5];
  endsequence

  chk_reset_five_tms: assert property ( // [R9]
    @(posedge i_tck) disable iff (!i_trst_n)
    tms_high_five |=> state_ff == ST_RESET)
    else $error("five TMS highs did not reach reset");

  chk_reset_ir_id: assert property ( // [R17]
    @(posedge i_tck) disable iff (!i_trst_n)
    state_ff == ST_RESET |=> ir_ff == OP_IDCODE)
    else $error("instruction not idcode after reset state");

  chk_bypass_zero: assert property ( // [R16]
    @(posedge i_tck) disable iff (!i_trst_n)
    state_ff == ST_CAP_DR |=> byp_ff == 1'b0)
    else $error("bypass did not capture zero");

  chk_id_capture: assert property ( // [R6]
    @(posedge i_tck) disable iff (!i_trst_n)
    state_ff == ST_CAP_DR |=> id_sh_ff[0] && id_sh_ff == ID_VALUE)
    else $error("identification value wrong at capture");

  chk_fixed_cells: assert property ( // [R10]
    @(posedge i_tck) disable iff (!i_trst_n)
    state_ff == ST_CAP_DR |=> bsr_sh_ff[CELL_FIXED_HI:CELL_FIXED_LO] == 2'b00)
    else $error("fixed cells did not capture zero");

  chk_tdo_enable: assert property ( // [R4]
    @(posedge i_tck) disable iff (!i_trst_n)
    o_tdo_oe == (state_ff == ST_SH_DR || state_ff == ST_SH_IR))
    else $error("serial out enable outside shift");

  chk_update_word: assert property ( // [R4]
    @(posedge i_tck) disable iff (!i_trst_n)
    state_ff == ST_UPD_DR && sel_bsr |=> bsr_upd_ff == $past(bsr_sh_ff))
    else $error("update register missed shifted word");

  chk_id_shift_out: assert property ( // [R5]
    @(posedge i_tck) disable iff (!i_trst_n)
    state_ff == ST_SH_DR && sel_id |=> o_tdo == id_sh_ff[0])
    else $error("identification bit not on serial out");

  chk_func_pass: assert property ( // [R3]
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !ext_s2_ff |=> cells_ff == $past(i_func_cells))
    else $error("functional value not passed outside extest");

  // Watches the pin, so the falling-edge stage is in the path
  chk_bypass_out: assert property ( // [R16]
    @(posedge i_tck) disable iff (!i_trst_n)
    state_ff == ST_CAP_DR && !sel_bsr && !sel_id |=> o_tdo == 1'b0)
    else $error("bypass capture not seen on serial out");

  chk_extest_drive: assert property ( // [R4]
    @(posedge i_core_clk) disable iff (!i_reset_n)
    ext_s2_ff |=> cells_ff == $past(upd_core_ff))
    else $error("update word not applied in extest");

endmodule // bst_tap
`default_nettype wire

/* File: bst_pkg.sv */
/*
 Boundary scan test port package: sizes, opcodes, cell positions,
 reset values and the controller state type.
 Assumes two consumers, the bst_tap module and the bst_tap_tb_top bench.
*/
`default_nettype none
package bst_pkg;
  // ==========================================
  // Sizes
  localparam int BSR_LEN = 81;
  localparam int IR_LEN = 4;
  localparam int ID_LEN = 32;
  // ==========================================
  // Opcodes, unlisted codes fall to bypass
  localparam logic [IR_LEN-1:0] OP_EXTEST = 4'h0;
  localparam logic [IR_LEN-1:0] OP_SAMPLE = 4'h1;
  localparam logic [IR_LEN-1:0] OP_IDCODE = 4'h2;
  localparam logic [IR_LEN-1:0] OP_BYPASS = 4'hF;
  localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;
  // ==========================================
  // Cell positions
  localparam int CELL_LOWER_LO_CTL = 0;
  localparam int CELL_LOWER_HI_CTL = 2;
  localparam int CELL_UPPER_CTL = 28;
  localparam int CELL_TEST_PIN = 36;
  localparam int CELL_SDA_OUT = 59;
  localparam int CELL_SDA_IN = 60;
  localparam int CELL_FIXED_LO = 79;
  localparam int CELL_FIXED_HI = 80;
  // Safe update values: cells 0, 2 and 59 at 1, the rest 0
  localparam logic [BSR_LEN-1:0] BSR_SAFE = 81'h800000000000005;
  // ==========================================
  // Identification fields; values are arbitrary
  localparam logic [15:0] ID_PART = 16'h5A5A;
  localparam logic [10:0] ID_MAKER = 11'h2B4;
  localparam logic ID_MARKER = 1'b1;
  // ==========================================
  // Controller states
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
    ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
    ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } bst_state_t;
endpackage
`default_nettype wire

/* File: bst_tester.sv */
/*
 Board tester model: drives the test port pins, collects serial data.
 Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module bst_tester (
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  output logic o_trst_n,
  input wire logic i_tdo,
  input wire logic i_tdo_oe
);
  // ==========================================
  // Pins and idle levels
  logic oe_ok;
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
    o_trst_n = 1'b0;
    oe_ok = 1'b1;
  end
  // ==========================================
  // One 64 ns period; clock rests low between frames
  task automatic tick(input logic tms, input logic di, input logic sh,
                      output logic dout);
    #1 o_tms = tms;
    o_tdi = sh ? di : ~o_tdi; // Toggled so idle data is never trusted
    #31 o_tck = 1'b1;
    dout = i_tdo;
    if (sh && i_tdo_oe !== 1'b1) oe_ok = 1'b0;
    #32 o_tck = 1'b0;
  endtask
  // One clock under test reset, so no start-up edge can be missed
  task automatic reset_tap();
    logic d;
    #7 o_trst_n = 1'b0;
    tick(1'b1, 1'b0, 1'b0, d);
    #5 o_trst_n = 1'b1;
    tms_reset();
  endtask
  // Five mode-select highs from any state, then on to idle
  task automatic tms_reset();
    logic d;
    repeat (5) tick(1'b1, 1'b0, 1'b0, d);
    tick(1'b0, 1'b0, 1'b0, d);
  endtask
  // ==========================================
  // Full scan from idle back to idle, LSB first
  task automatic scan(input logic ir, input logic [127:0] din,
                      input int len, output logic [127:0] dout);
    logic d;
    dout = '0;
    tick(1'b1, 1'b0, 1'b0, d);
    if (ir) tick(1'b1, 1'b0, 1'b0, d);
    tick(1'b0, 1'b0, 1'b0, d);
    tick(1'b0, 1'b0, 1'b0, d);
    for (int i = 0; i < len; i++) begin
      tick(i == len - 1, din[i], 1'b1, d);
      dout[i] = d;
    end
    tick(1'b1, 1'b0, 1'b0, d);
    tick(1'b0, 1'b0, 1'b0, d);
  endtask
  // Stops inside a data shift and pulls test reset, clock held still
  task automatic abort_scan(input int n);
    logic d;
    tick(1'b1, 1'b0, 1'b0, d);
    tick(1'b0, 1'b0, 1'b0, d);
    tick(1'b0, 1'b0, 1'b0, d);
    repeat (n) tick(1'b0, 1'b1, 1'b1, d);
    #20 o_trst_n = 1'b0;
  endtask
endmodule // bst_tester
`default_nettype wire

/* File: bst_tap_tb_top.sv */
/*
 Self-checking bench for the test port: tester model on the link side,
 random functional cell values on the core side.
 Assumes bst_pkg, bst_tap and bst_tester are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module bst_tap_tb_top;
  import bst_pkg::*;
  localparam logic [3:0] VER = 4'hA;
  logic core_clk, reset_n, tck, tms, tdi, trst_n, tdo, tdo_oe, func_run;
  logic lo_hiz, hi_hiz, up_hiz, sda_low, tst_low;
  logic [BSR_LEN-1:0] func, cells, pat, q;
  logic [127:0] got, din;
  logic [31:0] rng;
  logic [3:0] op;
  int error_cnt, comparisons;
  bst_tap #(.ID_VERSION(VER)) bst_tap_i (.i_core_clk(core_clk),
    .i_reset_n(reset_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .i_trst_n(trst_n), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
    .i_func_cells(func), .o_cells(cells), .o_lower_lo_hiz(lo_hiz),
    .o_lower_hi_hiz(hi_hiz), .o_upper_hiz(up_hiz),
    .o_sda_pull_low(sda_low), .o_test_pin_pull_low(tst_low));
  bst_tester bst_tester_i (.o_tck(tck), .o_tms(tms), .o_tdi(tdi),
    .o_trst_n(trst_n), .i_tdo(tdo), .i_tdo_oe(tdo_oe));
  // ==========================================
  // Expectations
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [BSR_LEN-1:0] rnd81();
    logic [95:0] w;
    w = {xs(), xs(), xs()};
    return w[BSR_LEN-1:0];
  endfunction
  function automatic logic [127:0] id_exp();
    return {96'h0, VER, ID_PART, ID_MAKER, 1'b1};
  endfunction
  function automatic logic [127:0] cap_exp(input logic [BSR_LEN-1:0] f);
    f[CELL_FIXED_LO] = 1'b0;
    f[CELL_FIXED_HI] = 1'b0;
    return 128'(f);
  endfunction
  function automatic logic [127:0] pins_exp(input logic [BSR_LEN-1:0] c);
    return 128'({c[0], c[2], ~c[28], ~c[59], c[36]});
  endfunction
  // ==========================================
  // Compare, wait and close
  task automatic cmp_vec(input logic [127:0] g, input logic [127:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Bounded wait; running out shows up as a mismatch
  task automatic wait_cells(input logic [BSR_LEN-1:0] e);
    for (int i = 0; i < 12 && cells !== e; i++) begin
      @(posedge core_clk);
      #1;
    end
    cmp_vec(128'(cells), 128'(e));
  endtask
  task automatic end_sim();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================
  // Clock, random functional values, watchdog
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) if (func_run) func <= #2 rnd81();
  initial begin
    #2000000;
    error_cnt++;
    end_sim();
  end
  // ==========================================
  // Main sequence
  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    func_run = 1'b0;
    func = '0;
    rng = 32'h00000041;
    error_cnt = 0;
    comparisons = 0;
    repeat (2) @(posedge core_clk);
    #2 cmp_vec(128'(cells), 128'(BSR_SAFE));
    reset_n = 1'b1;
    func_run = 1'b1;
    bst_tester_i.reset_tap();
    bst_tester_i.scan(1'b0, 128'(rnd81()), 32, got);
    cmp_vec(got, id_exp());
    for (int k = 0; k < 3; k++) begin
      op = (k == 0) ? OP_IDCODE : (k == 1) ? OP_BYPASS : 4'h7;
      bst_tester_i.scan(1'b1, 128'(op), 4, got);
      cmp_vec(got, 128'(IR_CAPTURE));
      din = 128'(rnd81());
      bst_tester_i.scan(1'b0, din, 32, got);
      cmp_vec(got, (k == 0) ? id_exp() : {96'h0, din[30:0], 1'b0});
    end
    // Mode select alone must leave bypass and bring back idcode
    bst_tester_i.tms_reset();
    bst_tester_i.scan(1'b0, 128'(rnd81()), 32, got);
    cmp_vec(got, id_exp());
    func_run = 1'b0;
    @(posedge core_clk);
    #2 wait_cells(func);
    pat = rnd81();
    bst_tester_i.scan(1'b1, 128'(OP_SAMPLE), 4, got);
    bst_tester_i.scan(1'b0, 128'(pat), BSR_LEN, got);
    cmp_vec(got, cap_exp(func));
    bst_tester_i.scan(1'b1, 128'(OP_EXTEST), 4, got);
    wait_cells(pat);
    for (int k = 0; k < 4; k++) begin
      cmp_vec(128'({lo_hiz, hi_hiz, up_hiz, sda_low, tst_low}),
              pins_exp(cells));
      @(posedge core_clk);
      #2 func = rnd81();
      q = (k == 0) ? '1 : (k == 1) ? '0 : rnd81();
      bst_tester_i.scan(1'b0, 128'(q), BSR_LEN, got);
      cmp_vec(got, cap_exp(func));
      wait_cells(q);
    end
    bst_tester_i.abort_scan(20);
    #5 cmp_vec(128'(tdo_oe), 128'h0);
    wait_cells(func);
    bst_tester_i.reset_tap();
    bst_tester_i.scan(1'b0, 128'(rnd81()), 32, got);
    cmp_vec(got, id_exp());
    cmp_vec(128'(bst_tester_i.oe_ok), 128'h1);
    end_sim();
  end
endmodule // bst_tap_tb_top
`default_nettype wire
